// file: crs_pkg.sv
// ----------------------------------------------------------------------
// Shared constants and types for the register stack core
// ----------------------------------------------------------------------
package crs_pkg;

    // ------------------------------------------------------------------
    // Memory map of the core
    // ------------------------------------------------------------------
    localparam logic [11:0] DATA_BASE = 12'h000;      // Data space start
    localparam logic [11:0] PROG_BASE = 12'hc00;      // Program space start
    localparam logic [11:0] STACK_BASE = 12'h030;     // Stack window 0x30-0x3f
    localparam logic [11:0] PC_RESET_ADDR = 12'hc00;  // First fetch after reset
    localparam logic [9:0] PC_RESET = PC_RESET_ADDR[9:0];
    localparam logic [3:0] SP_RESET = 4'hf;           // Points at 0x3f
    localparam logic [3:0] SP_STEP = 4'h2;            // Two bytes per address
    localparam int IX_SPACE_BIT = 10;                 // Space select bit

    // ------------------------------------------------------------------
    // Status flag positions and reset value
    // ------------------------------------------------------------------
    localparam int FL_C = 0;                          // Carry / borrow
    localparam int FL_H = 1;                          // Half carry
    localparam int FL_Z = 2;                          // Zero
    localparam int FL_N = 3;                          // Negative
    localparam int FL_G = 4;                          // Global interrupt mask
    localparam int FL_R = 5;                          // Nonvolatile write busy
    localparam logic [7:0] SR_RESET = 8'h00;          // Mask clear after reset
    localparam logic [7:0] SR_SW_MASK = 8'h1f;        // Bits software may write
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [10:0] IX_RESET = 11'h000;

    // ------------------------------------------------------------------
    // APB register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] REG_ACC = 12'h000;
    localparam logic [11:0] REG_IX = 12'h004;
    localparam logic [11:0] REG_PC = 12'h008;
    localparam logic [11:0] REG_SP = 12'h00c;
    localparam logic [11:0] REG_SR = 12'h010;

    // ------------------------------------------------------------------
    // Sequencer commands and their carrier
    // ------------------------------------------------------------------
    typedef enum logic [4:0] {
        OP_NONE, OP_ALU, OP_LOGIC, OP_LD_ACC, OP_RLC, OP_RRC,
        OP_LDC, OP_INVERT_CARRY, OP_SETG, OP_LD_IX, OP_LD_SP, OP_JUMP,
        OP_CALL, OP_RET, OP_RETI, OP_IRQ, OP_IDX_RD, OP_IDX_WR
    } crs_op_t;

    typedef struct packed {
        crs_op_t op;          // What to do
        logic [7:0] data;     // Result, operand, offset or write byte
        logic [9:0] target;   // Jump, call or vector address
        logic carry;          // Carry out, carry bit, mask bit or space bit
        logic half;           // Half carry out
        logic [1:0] pc_adv;   // Instruction length in bytes
    } crs_cmd_t;

endpackage : crs_pkg

// file: crs_register_stack.sv
// Behaviour
// [RULE1] Effective address is pointer plus unsigned offset
// [RULE2] Pointer low ten bits locate within space
// [RULE3] Pointer top bit selects data or program
// [RULE4] Indexed writes to program space are dropped
// [RULE5] Ten-bit counter, resets to 0xc00
// [RULE6] Four-bit stack pointer within 0x30-0x3f
// [RULE7] Stack pointer resets to 0xf
// [RULE8] Push moves stack pointer down by two
// [RULE9] Pull moves stack pointer up by two
// [RULE10] Pointer marks next free slot; write first
// [RULE11] Call pushes return address, low byte first
// [RULE12] Return reloads counter from stacked address
// [RULE13] Eight-bit status with C H Z N G R
// [RULE14] Carry from ALU; rotates go through carry
// [RULE15] Load-carry and invert-carry act on carry
// [RULE16] Half carry records nibble boundary overflow
// [RULE17] Zero flag set on zero result
// [RULE18] Negative flag copies result top bit
// [RULE19] Accumulator is eight-bit general register
// [RULE20] Interrupt entry pushes, clears mask, five cycles
// [RULE21] Return pulls high byte before low byte
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module crs_register_stack
    import crs_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmd_valid,
    input wire crs_cmd_t cmd,
    input wire logic [7:0] mem_rdata,
    input wire logic nv_write_busy,
    output logic busy,
    output logic [11:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_we,
    output logic mem_re,
    output logic [7:0] accumulator,
    output logic [10:0] index_pointer,
    output logic [9:0] program_counter,
    output logic [3:0] stack_pointer,
    output logic [7:0] status_flags
);

    // ------------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------------
    // Data address of a stack slot
    function automatic logic [11:0] stack_addr(input logic [3:0] slot);
        stack_addr = STACK_BASE | {8'h00, slot};
    endfunction : stack_addr

    // Indexed effective address; the low ten bits wrap inside the space
    function automatic logic [11:0] eff_addr(input logic [10:0] ix, input logic [7:0] off);
        logic [9:0] loc;
        loc = ix[9:0] + {2'b00, off};
        eff_addr = (ix[IX_SPACE_BIT] ? PROG_BASE : DATA_BASE) | {2'b00, loc};
    endfunction : eff_addr

    // ------------------------------------------------------------------
    // Sequence state
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_PUSH_LO, ST_PUSH_HI, ST_IRQ_W1, ST_IRQ_W2,
        ST_POP_HI, ST_POP_LO, ST_POP_END, ST_IDX_WAIT, ST_IDX_LOAD
    } crs_state_t;

    crs_state_t state;        // Current step
    crs_state_t next_state;   // Step after this edge
    logic go;                 // Command taken this cycle
    logic is_irq;             // Push belongs to interrupt entry
    logic is_reti;            // Pull belongs to interrupt return
    logic [9:0] saved_target; // Call target or vector
    logic [7:0] hi_byte;      // High byte pulled first
    logic [11:0] ret_full;    // Return address in full map form
    logic acc_rdy;            // APB access phase
    logic apb_wr;             // APB write completes this edge
    logic [7:0] alu_res;      // Result steering flags

    assign go = cmd_valid && (state == ST_IDLE);
    assign ret_full = PROG_BASE | {2'b00, program_counter};
    assign acc_rdy = psel && penable;
    assign apb_wr = acc_rdy && pready && pwrite;

    // Rotations through carry, result for flags
    always_comb begin
        case (cmd.op)
            OP_RLC: alu_res = {accumulator[6:0], status_flags[FL_C]}; // RULE14
            OP_RRC: alu_res = {status_flags[FL_C], accumulator[7:1]}; // RULE14
            default: alu_res = cmd.data;
        endcase
    end

    // Next step of a multi-cycle sequence
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (go) begin
                    case (cmd.op)
                        OP_CALL, OP_IRQ: next_state = ST_PUSH_LO;
                        OP_RET, OP_RETI: next_state = ST_POP_HI;
                        OP_IDX_RD: next_state = ST_IDX_WAIT;
                        default: next_state = ST_IDLE;
                    endcase
                end
            end
            ST_PUSH_LO: next_state = ST_PUSH_HI;
            ST_PUSH_HI: next_state = is_irq ? ST_IRQ_W1 : ST_IDLE;
            ST_IRQ_W1: next_state = ST_IRQ_W2; // RULE20
            ST_IRQ_W2: next_state = ST_IDLE;
            ST_POP_HI: next_state = ST_POP_LO;
            ST_POP_LO: next_state = ST_POP_END;
            ST_POP_END: next_state = ST_IDLE;
            ST_IDX_WAIT: next_state = ST_IDX_LOAD;
            ST_IDX_LOAD: next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // State register; busy tells the sequencer to hold off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            busy <= (next_state != ST_IDLE);
        end
    end

    // Context captured when a sequence starts, and the high byte in the middle of a pull
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            is_irq <= 1'b0;
            is_reti <= 1'b0;
            saved_target <= 10'h000;
            hi_byte <= 8'h00;
        end else begin
            if (go) begin
                is_irq <= (cmd.op == OP_IRQ);
                is_reti <= (cmd.op == OP_RETI);
                saved_target <= cmd.target;
            end
            // Read data trails its strobe by one cycle
            if (state == ST_POP_LO) begin
                hi_byte <= mem_rdata; // RULE21
            end
        end
    end

    // ------------------------------------------------------------------
    // Memory port
    // ------------------------------------------------------------------
    // Strobes are single-cycle; address and data hold between them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            mem_addr <= 12'h000;
            mem_wdata <= 8'h00;
        end else begin
            mem_we <= 1'b0;
            mem_re <= 1'b0;
            if (go) begin
                case (cmd.op)
                    OP_CALL, OP_IRQ: begin
                        // Write at the free slot before moving
                        mem_we <= 1'b1;
                        mem_addr <= stack_addr(stack_pointer); // RULE10
                        mem_wdata <= ret_full[7:0]; // RULE11
                    end
                    OP_RET, OP_RETI: begin
                        mem_re <= 1'b1;
                        mem_addr <= stack_addr(stack_pointer + 4'h1); // RULE21
                    end
                    OP_IDX_RD: begin
                        mem_re <= 1'b1;
                        mem_addr <= eff_addr(index_pointer, cmd.data); // RULE1 RULE2 RULE3
                    end
                    OP_IDX_WR: begin
                        // Code memory is read-only through the pointer
                        mem_we <= !index_pointer[IX_SPACE_BIT]; // RULE4
                        mem_addr <= eff_addr(index_pointer, cmd.data); // RULE1
                        mem_wdata <= cmd.data;
                    end
                    default: ;
                endcase
            end else if (state == ST_PUSH_LO) begin
                mem_we <= 1'b1;
                mem_addr <= stack_addr(stack_pointer - 4'h1); // RULE11
                mem_wdata <= {4'h0, ret_full[11:8]};
            end else if (state == ST_POP_HI) begin
                mem_re <= 1'b1;
                mem_addr <= stack_addr(stack_pointer + SP_STEP); // RULE21
            end
        end
    end

    // ------------------------------------------------------------------
    // Programmer-visible registers
    // ------------------------------------------------------------------
    // Accumulator; core activity wins over a bus write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator <= ACC_RESET;
        end else if (go && (cmd.op inside {OP_ALU, OP_LOGIC, OP_LD_ACC, OP_RLC, OP_RRC})) begin
            accumulator <= alu_res; // RULE19
        end else if (state == ST_IDX_LOAD) begin
            // Read data only stands one cycle after the memory took the strobe
            accumulator <= mem_rdata; // RULE19
        end else if (apb_wr && paddr == REG_ACC) begin
            accumulator <= pwdata[7:0];
        end
    end

    // Index pointer, space bit included
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            index_pointer <= IX_RESET;
        end else if (go && cmd.op == OP_LD_IX) begin
            index_pointer <= {cmd.carry, cmd.target}; // RULE3
        end else if (apb_wr && paddr == REG_IX) begin
            index_pointer <= pwdata[10:0];
        end
    end

    // Program counter holds the offset inside program space
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter <= PC_RESET; // RULE5
        end else if (go) begin
            case (cmd.op)
                OP_JUMP: program_counter <= cmd.target;
                OP_CALL, OP_RET, OP_RETI, OP_IRQ: ;
                default: program_counter <= program_counter + {8'h00, cmd.pc_adv};
            endcase
        end else if (state == ST_PUSH_HI && !is_irq) begin
            program_counter <= saved_target; // RULE11
        end else if (state == ST_IRQ_W2) begin
            program_counter <= saved_target; // RULE20
        end else if (state == ST_POP_END) begin
            program_counter <= {hi_byte[1:0], mem_rdata}; // RULE12
        end else if (apb_wr && paddr == REG_PC) begin
            program_counter <= pwdata[9:0];
        end
    end

    // Stack pointer; wraps inside the sixteen-byte window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_pointer <= SP_RESET; // RULE7
        end else if (state == ST_PUSH_HI) begin
            stack_pointer <= stack_pointer - SP_STEP; // RULE8
        end else if (state == ST_POP_END) begin
            stack_pointer <= stack_pointer + SP_STEP; // RULE9
        end else if (go && cmd.op == OP_LD_SP) begin
            stack_pointer <= cmd.data[3:0]; // RULE6
        end else if (apb_wr && paddr == REG_SP) begin
            stack_pointer <= pwdata[3:0]; // RULE6
        end
    end

    // Status flags; hardware updates win over software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_flags <= SR_RESET;
        end else begin
            if (go) begin
                case (cmd.op)
                    OP_ALU: begin
                        status_flags[FL_C] <= cmd.carry; // RULE14
                        status_flags[FL_H] <= cmd.half; // RULE16
                        status_flags[FL_Z] <= (alu_res == 8'h00); // RULE17
                        status_flags[FL_N] <= alu_res[7]; // RULE18
                    end
                    OP_LOGIC: begin
                        status_flags[FL_Z] <= (alu_res == 8'h00); // RULE17
                        status_flags[FL_N] <= alu_res[7]; // RULE18
                    end
                    OP_RLC: begin
                        status_flags[FL_C] <= accumulator[7]; // RULE14
                        status_flags[FL_Z] <= (alu_res == 8'h00);
                        status_flags[FL_N] <= alu_res[7];
                    end
                    OP_RRC: begin
                        status_flags[FL_C] <= accumulator[0]; // RULE14
                        status_flags[FL_Z] <= (alu_res == 8'h00);
                        status_flags[FL_N] <= alu_res[7];
                    end
                    OP_LDC: status_flags[FL_C] <= cmd.carry; // RULE15
                    OP_INVERT_CARRY: status_flags[FL_C] <= !status_flags[FL_C]; // RULE15
                    OP_SETG: status_flags[FL_G] <= cmd.carry;
                    default: ;
                endcase
            end else if (state == ST_IRQ_W2) begin
                status_flags[FL_G] <= 1'b0; // RULE20
            end else if (state == ST_POP_END && is_reti) begin
                status_flags[FL_G] <= 1'b1;
            end else if (apb_wr && paddr == REG_SR) begin
                status_flags[4:0] <= pwdata[4:0] & SR_SW_MASK[4:0];
            end
            // Write-busy mirrors the nonvolatile controller
            status_flags[FL_R] <= nv_write_busy; // RULE13
            status_flags[7:6] <= 2'b00;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // One wait state: read data is registered on the same edge that pready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= acc_rdy && !pready;
            pslverr <= 1'b0;
            if (acc_rdy && !pready) begin
                case (paddr)
                    REG_ACC: prdata <= {24'h0, accumulator};
                    // Space bit is write-only and reads as zero
                    REG_IX: prdata <= {22'h0, 10'(index_pointer[9:0])}; // RULE3
                    REG_PC: prdata <= {22'h0, program_counter};
                    REG_SP: prdata <= {28'h0, stack_pointer};
                    REG_SR: prdata <= {24'h0, status_flags};
                    default: begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_reset_values;
        $rose(presetn) |-> program_counter == PC_RESET && stack_pointer == SP_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("bad reset values"); // RULE5

    property p_call_push;
        go && cmd.op == OP_CALL |=> mem_we && mem_addr == stack_addr(stack_pointer)
            && mem_wdata == $past(ret_full[7:0]) ##1 mem_we
            && mem_addr == stack_addr($past(stack_pointer, 2) - 4'h1);
    endproperty
    a_call_push: assert property (p_call_push) else $error("call push order wrong"); // RULE11

    property p_call_sp;
        go && cmd.op == OP_CALL |=> ##2 stack_pointer == $past(stack_pointer, 3) - SP_STEP
            && program_counter == $past(cmd.target, 3);
    endproperty
    a_call_sp: assert property (p_call_sp) else $error("call pointer update wrong"); // RULE8

    property p_ret_sp;
        go && cmd.op == OP_RET |=> ##3 stack_pointer == $past(stack_pointer, 4) + SP_STEP;
    endproperty
    a_ret_sp: assert property (p_ret_sp) else $error("return pointer update wrong"); // RULE9

    property p_ret_pc;
        state == ST_POP_END |=> program_counter == {$past(hi_byte[1:0]), $past(mem_rdata)};
    endproperty
    a_ret_pc: assert property (p_ret_pc) else $error("return address not loaded"); // RULE12

    property p_ret_order;
        go && cmd.op == OP_RET |=> mem_re && mem_addr == stack_addr($past(stack_pointer) + 4'h1)
            ##1 mem_re && mem_addr == stack_addr($past(stack_pointer, 2) + SP_STEP);
    endproperty
    a_ret_order: assert property (p_ret_order) else $error("pull order wrong"); // RULE21

    property p_irq_five;
        go && cmd.op == OP_IRQ |=> busy [*4] ##1 !busy && !status_flags[FL_G]
            && program_counter == $past(cmd.target, 5);
    endproperty
    a_irq_five: assert property (p_irq_five) else $error("interrupt entry timing wrong"); // RULE20

    property p_code_write;
        mem_we |-> !mem_addr[11];
    endproperty
    a_code_write: assert property (p_code_write) else $error("write into program space"); // RULE4

    property p_zero_neg;
        go && cmd.op inside {OP_ALU, OP_LOGIC} |=> status_flags[FL_Z] == (accumulator == 8'h00)
            && status_flags[FL_N] == accumulator[7];
    endproperty
    a_zero_neg: assert property (p_zero_neg) else $error("zero or negative flag wrong"); // RULE17

    property p_invert_carry;
        go && cmd.op == OP_INVERT_CARRY |=> status_flags[FL_C] != $past(status_flags[FL_C]);
    endproperty
    a_invert_carry: assert property (p_invert_carry) else $error("carry not inverted"); // RULE15

    property p_idx_space;
        go && cmd.op == OP_IDX_RD |=> mem_addr[11:10] == {2{$past(index_pointer[IX_SPACE_BIT])}};
    endproperty
    a_idx_space: assert property (p_idx_space) else $error("indexed space wrong"); // RULE3

    c_call: cover property (go && cmd.op == OP_CALL ##2 state == ST_IDLE);
    c_ret: cover property (go && cmd.op == OP_RETI ##4 status_flags[FL_G]);
    c_irq: cover property (go && cmd.op == OP_IRQ ##5 !busy);
    c_apb_err: cover property (pslverr && pready);

endmodule : crs_register_stack

`default_nettype wire

// file: crs_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Byte memory for data and code space
// ----------------------------------------
module crs_mem_model (
    input wire logic pclk,
    input wire logic [11:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_we,
    input wire logic mem_re,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095]; // Whole map
    // Data one cycle after the strobe; churns otherwise so stale reads show
    // Plain always: the bench preloads cells through the hierarchy
    always @(posedge pclk) begin
        if (mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end
        mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
    end
endmodule : crs_mem_model
`default_nettype wire

// file: cpu_register_stack_core_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_register_stack_core_tb_top;
    import crs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, err, cmd_valid = 0, nvb = 0, busy;
    crs_cmd_t cmd = '0;
    logic [7:0] mem_rdata, mem_wdata, acc, sr;
    logic [11:0] mem_addr;
    logic mem_we, mem_re;
    logic [10:0] ix;
    logic [9:0] pc;
    logic [3:0] sp;
    int n_errors = 0, check_count = 0;
    always #25 pclk = ~pclk; // 20 MHz
    crs_register_stack i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd(cmd), .mem_rdata(mem_rdata),
        .nv_write_busy(nvb), .busy(busy), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .accumulator(acc), .index_pointer(ix), .program_counter(pc),
        .stack_pointer(sp), .status_flags(sr));
    crs_mem_model i_mem (.pclk(pclk), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re),
        .mem_rdata(mem_rdata));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s: expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) chk("pready", 0, 1);
        rd = prdata;
        err = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    // One sequencer command, then wait for busy to drop
    task go(input crs_op_t op, input logic [7:0] d, input logic [9:0] t,
            input logic c, input logic h);
        int n;
        n = 0;
        @(posedge pclk);
        cmd_valid <= 1; cmd <= '{op, d, t, c, h, 2'h1};
        @(posedge pclk);
        cmd_valid <= 0;
        do begin
            @(posedge pclk);
            n++;
        end while (busy === 1'b1 && n < 20);
        if (busy === 1'b1) chk("busy", 0, 1);
        @(negedge pclk);
    endtask : go
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        apb(0, REG_PC, 0); chk("pc", rd, 0);
        apb(0, REG_SP, 0); chk("sp", rd, 32'hf);
        apb(0, REG_SR, 0); chk("sr", rd, 0);
    endtask : t_reset
    task t_regs;
        apb(1, REG_SP, 32'h9); apb(0, REG_SP, 0); chk("sp", rd, 32'h9);
        apb(1, REG_IX, 32'h7ff); apb(0, REG_IX, 0); chk("ix", rd, 32'h3ff);
        apb(0, 12'h014, 0); chk("pslverr", err, 1);
        chk("rd", rd, 0);
        apb(1, REG_SR, 32'hff);
        apb(0, REG_SR, 0);
        chk("sr", rd, 32'h1f);
        apb(1, REG_SR, 0);
        apb(1, REG_SP, 32'hf);
    endtask : t_regs
    task t_call;
        go(OP_JUMP, 0, 10'h123, 0, 0);
        go(OP_CALL, 0, 10'h200, 0, 0);
        chk("lo", i_mem.mem[12'h03f], 8'h23);
        chk("hi", i_mem.mem[12'h03e], 8'h0d);
        chk("sp", sp, 4'hd);
        chk("pc", pc, 10'h200);
        go(OP_RET, 0, 0, 0, 0);
        chk("pc", pc, 10'h123);
        chk("sp", sp, 4'hf);
    endtask : t_call
    task t_flags;
        go(OP_ALU, 8'h00, 0, 1, 1); chk("sr", sr, 8'h07);
        go(OP_ALU, 8'h80, 0, 0, 0); chk("sr", sr, 8'h08);
        chk("acc", acc, 8'h80);
        go(OP_INVERT_CARRY, 0, 0, 0, 0); chk("sr", sr, 8'h09);
        go(OP_RLC, 8'h80, 0, 0, 0); chk("acc", acc, 8'h01);
        go(OP_ALU, 8'h10, 0, 0, 1); chk("sr", sr, 8'h02);
        nvb <= 1;
        go(OP_LDC, 0, 0, 1, 0); chk("sr", sr, 8'h23);
        go(OP_LD_ACC, 8'h02, 0, 0, 0); chk("acc", acc, 8'h02);
        go(OP_RRC, 0, 0, 0, 0); chk("acc", acc, 8'h81);
        chk("sr", sr, 8'h2a);
        go(OP_LOGIC, 8'h00, 0, 1, 1); chk("sr", sr, 8'h26);
        nvb <= 0;
    endtask : t_flags
    task t_index;
        i_mem.mem[12'hc15] = 8'h3c;
        go(OP_LD_IX, 0, 10'h010, 1, 0);
        chk("ix", ix, 11'h410);
        go(OP_IDX_WR, 8'h5a, 0, 0, 0);
        go(OP_IDX_WR, 8'h05, 0, 0, 0);
        chk("code", i_mem.mem[12'hc15], 8'h3c);
        go(OP_IDX_RD, 8'h05, 0, 0, 0); chk("acc", acc, 8'h3c);
        go(OP_LD_IX, 0, 10'h020, 0, 0);
        go(OP_IDX_WR, 8'hf0, 0, 0, 0);
        go(OP_IDX_RD, 8'hf0, 0, 0, 0); chk("acc", acc, 8'hf0);
    endtask : t_index
    task t_irq;
        go(OP_JUMP, 0, 10'h155, 0, 0);
        go(OP_LD_SP, 8'h09, 0, 0, 0); chk("sp", sp, 4'h9);
        go(OP_SETG, 0, 0, 1, 0); chk("g", sr[FL_G], 1);
        go(OP_IRQ, 0, 10'h3f0, 0, 0); chk("pc", pc, 10'h3f0);
        chk("g", sr[FL_G], 0);
        chk("sp", sp, 4'h7);
        chk("lo", i_mem.mem[12'h039], 8'h57);
        go(OP_RETI, 0, 0, 0, 0); chk("pc", pc, 10'h157);
        chk("g", sr[FL_G], 1);
        chk("sp", sp, 4'h9);
    endtask : t_irq
    task t_rst2;
        @(posedge pclk);
        presetn <= 0;
        @(posedge pclk);
        presetn <= 1;
        @(negedge pclk);
        chk("sp", sp, 4'hf);
        chk("pc", pc, 10'h000);
        chk("acc", acc, 8'h00);
    endtask : t_rst2
    task give_verdict;
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        t_reset(); t_regs(); t_call(); t_flags(); t_index(); t_irq(); t_rst2();
        give_verdict();
    end
endmodule : cpu_register_stack_core_tb_top
`default_nettype wire
